// File: hdl/lmr_pkg.sv
// lmr_pkg: opcodes, flag layout and carrier types for the long move/or/rotate
// datapath; assumes an 8-bit data memory and one core clock.
package lmr_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int MEM_DEPTH = 256;

  // status flag positions inside the flag word
  localparam int FLAG_W = 2;
  // must match the member order of lmr_flags_type: null flag is the high bit
  localparam int FLAG_NULL_POS = 1;
  localparam int FLAG_SHIFT_POS = 0;

  localparam logic [DATA_W-1:0] WORK_RESET = 8'h00;
  localparam logic [FLAG_W-1:0] FLAG_RESET = 2'h0;

  // high bit of the byte, the one that rotates out
  localparam int MSB_POS = DATA_W - 1;

  typedef enum logic [3:0] {
    LMR_OP_NONE,
    LMR_OP_MOVE_TO_WORK,
    LMR_OP_MOVE_TO_MEM,
    LMR_OP_OR,
    LMR_OP_OR_TO_MEM,
    LMR_OP_ROT,
    LMR_OP_ROT_TO_WORK,
    LMR_OP_ROT_FLAG,
    LMR_OP_ROT_FLAG_TO_WORK
  } lmr_op_type;

  typedef struct packed {
    lmr_op_type op;
    logic [ADDR_W-1:0] addr;
  } lmr_cmd_type;

  typedef struct packed {
    logic result_null_flag;
    logic shift_out_flag;
  } lmr_flags_type;

endpackage : lmr_pkg

// File: hdl/lmr_mem.sv
// lmr_mem: byte-wide data memory with registered read data.
// assumes one write port and one read port on the core clock.
`timescale 1ns/1ps
module lmr_mem
  import lmr_pkg::*;
#(
  parameter int DEPTH = MEM_DEPTH,
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
)
(
  input wire logic clk_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [DW-1:0] wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [DW-1:0] rd_data_o
);

  logic [DW-1:0] mem [DEPTH];

  // no reset on the array; contents are defined by software writes
  always_ff @(posedge clk_i)
  begin
    if (wr_en_i)
    begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end

endmodule : lmr_mem

// File: hdl/lmr_datapath.sv
// lmr_datapath: executes the long move, or and rotate-left instructions.
// assumes the decoder presents one command with a valid strobe and waits
// for done before the next; memory lives in lmr_mem.
`timescale 1ns/1ps
module lmr_datapath
  import lmr_pkg::*;
(
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic CMD_VALID_I,
  input wire lmr_cmd_type CMD_I,
  output logic CMD_READY_O,
  output logic DONE_O,
  input wire logic MEM_LOAD_VALID_I,
  input wire logic [ADDR_W-1:0] MEM_LOAD_ADDR_I,
  input wire logic [DATA_W-1:0] MEM_LOAD_DATA_I,
  input wire logic WORK_LOAD_VALID_I,
  input wire logic [DATA_W-1:0] WORK_LOAD_DATA_I,
  input wire logic FLAG_LOAD_VALID_I,
  input wire lmr_flags_type FLAG_LOAD_I,
  input wire logic [ADDR_W-1:0] MEM_PEEK_ADDR_I,
  output logic [DATA_W-1:0] MEM_PEEK_DATA_O,
  output logic [DATA_W-1:0] WORK_O,
  output lmr_flags_type FLAGS_O
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_EXEC
  } lmr_state_type;

  lmr_state_type state;
  lmr_state_type next_state;
  lmr_cmd_type cmd;
  lmr_cmd_type next_cmd;
  logic [DATA_W-1:0] work;
  logic [DATA_W-1:0] next_work;
  lmr_flags_type flags;
  lmr_flags_type next_flags;
  logic done;
  logic next_done;

  logic mem_wr_en;
  logic [ADDR_W-1:0] mem_wr_addr;
  logic [DATA_W-1:0] mem_wr_data;
  logic [ADDR_W-1:0] mem_rd_addr;
  logic [DATA_W-1:0] mem_rd_data;

  logic [DATA_W-1:0] or_result;
  logic [DATA_W-1:0] rot_result;
  logic [DATA_W-1:0] rot_flag_result;

  // one shared read port; peeks only when idle to avoid a second port
  lmr_mem u_mem (
    .clk_i(CLK_I),
    .wr_en_i(mem_wr_en),
    .wr_addr_i(mem_wr_addr),
    .wr_data_i(mem_wr_data),
    .rd_addr_i(mem_rd_addr),
    .rd_data_o(mem_rd_data)
  );

  assign or_result = work | mem_rd_data;
  assign rot_result = {mem_rd_data[MSB_POS-1:0], mem_rd_data[MSB_POS]};
  assign rot_flag_result = {mem_rd_data[MSB_POS-1:0], flags.shift_out_flag};

  assign CMD_READY_O = (state == ST_IDLE);
  assign DONE_O = done;
  assign WORK_O = work;
  assign FLAGS_O = flags;
  assign MEM_PEEK_DATA_O = mem_rd_data;
  assign mem_rd_addr = (state == ST_IDLE) ? MEM_PEEK_ADDR_I : cmd.addr;

  always_comb
  begin
    next_state = state;
    next_cmd = cmd;
    next_work = work;
    next_flags = flags;
    next_done = 1'b0;
    mem_wr_en = 1'b0;
    mem_wr_addr = cmd.addr;
    mem_wr_data = work;
    case (state)
      ST_IDLE:
      begin
        if (CMD_VALID_I)
        begin
          next_cmd = CMD_I;
          next_state = ST_READ;
        end
        else
        begin
          // preload path for the core around this block
          mem_wr_en = MEM_LOAD_VALID_I;
          mem_wr_addr = MEM_LOAD_ADDR_I;
          mem_wr_data = MEM_LOAD_DATA_I;
          if (WORK_LOAD_VALID_I)
          begin
            next_work = WORK_LOAD_DATA_I;
          end
          if (FLAG_LOAD_VALID_I)
          begin
            next_flags = FLAG_LOAD_I;
          end
        end
      end
      ST_READ:
      begin
        // registered read data arrive next cycle
        next_state = ST_EXEC;
      end
      ST_EXEC:
      begin
        next_state = ST_IDLE;
        next_done = 1'b1;
        case (cmd.op)
          LMR_OP_MOVE_TO_WORK:
          begin
            next_work = mem_rd_data;
          end
          LMR_OP_MOVE_TO_MEM:
          begin
            mem_wr_en = 1'b1;
            mem_wr_data = work;
          end
          LMR_OP_OR:
          begin
            next_work = or_result;
            next_flags.result_null_flag = (or_result == '0);
          end
          LMR_OP_OR_TO_MEM:
          begin
            mem_wr_en = 1'b1;
            mem_wr_data = or_result;
            next_flags.result_null_flag = (or_result == '0);
          end
          LMR_OP_ROT:
          begin
            mem_wr_en = 1'b1;
            mem_wr_data = rot_result;
          end
          LMR_OP_ROT_TO_WORK:
          begin
            next_work = rot_result;
          end
          LMR_OP_ROT_FLAG:
          begin
            mem_wr_en = 1'b1;
            mem_wr_data = rot_flag_result;
            next_flags.shift_out_flag = mem_rd_data[MSB_POS];
          end
          LMR_OP_ROT_FLAG_TO_WORK:
          begin
            next_work = rot_flag_result;
            next_flags.shift_out_flag = mem_rd_data[MSB_POS];
          end
          default:
          begin
            next_done = 1'b1;
          end
        endcase
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      state <= ST_IDLE;
      cmd <= '0;
      work <= WORK_RESET;
      flags <= FLAG_RESET;
      done <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cmd <= next_cmd;
      work <= next_work;
      flags <= next_flags;
      done <= next_done;
    end
  end

endmodule : lmr_datapath

// File: dv/lmr_datapath_asserts.sv
// lmr_datapath_asserts: retire timing and flag relations of the datapath.
// bound to lmr_datapath; sees work and flags, not the memory.
`timescale 1ns/1ps
module lmr_datapath_asserts
  import lmr_pkg::*;
(
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic CMD_VALID_I,
  input wire lmr_cmd_type CMD_I,
  input wire logic CMD_READY_O,
  input wire logic DONE_O,
  input wire logic [DATA_W-1:0] WORK_O,
  input wire lmr_flags_type FLAGS_O
);
  lmr_op_type op;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  // op kept from take; FLAGS_O[1] null flag, FLAGS_O[0] shift-out flag
  always_ff @(posedge CLK_I or negedge NRST_I)
    if (!NRST_I) op <= LMR_OP_NONE;
    else if (CMD_VALID_I && CMD_READY_O) op <= CMD_I.op;
  property p_take; CMD_VALID_I && CMD_READY_O |->
    ##1 !CMD_READY_O [*2] ##1 DONE_O && CMD_READY_O; endproperty
  a_take: assert property (p_take) else $error("retire timing");
  property p_kf; DONE_O && op inside {LMR_OP_MOVE_TO_WORK,
    LMR_OP_ROT_TO_WORK} |-> $stable(FLAGS_O); endproperty
  a_kf: assert property (p_kf) else $error("flags moved");
  property p_ka; DONE_O && op inside {LMR_OP_MOVE_TO_MEM, LMR_OP_ROT} |->
    $stable(FLAGS_O) && $stable(WORK_O); endproperty
  a_ka: assert property (p_ka) else $error("state moved");
  property p_or; DONE_O && op == LMR_OP_OR |->
    (WORK_O | $past(WORK_O)) == WORK_O && $stable(FLAGS_O[0]); endproperty
  a_or: assert property (p_or) else $error("or result");
  property p_nul; DONE_O && op == LMR_OP_OR |->
    FLAGS_O[1] == (WORK_O == 8'h00); endproperty
  a_nul: assert property (p_nul) else $error("null flag");
  property p_om; DONE_O && op == LMR_OP_OR_TO_MEM |->
    $stable(WORK_O) && $stable(FLAGS_O[0]); endproperty
  a_om: assert property (p_om) else $error("or to mem");
  property p_rf; DONE_O && op == LMR_OP_ROT_FLAG |->
    $stable(WORK_O) && $stable(FLAGS_O[1]); endproperty
  a_rf: assert property (p_rf) else $error("rotate flag");
  property p_rfw; DONE_O && op == LMR_OP_ROT_FLAG_TO_WORK |->
    WORK_O[0] == $past(FLAGS_O[0]) && $stable(FLAGS_O[1]); endproperty
  a_rfw: assert property (p_rfw) else $error("rotate flag work");
endmodule : lmr_datapath_asserts
bind lmr_datapath lmr_datapath_asserts u_chk (.CLK_I, .NRST_I, .CMD_VALID_I,
  .CMD_I, .CMD_READY_O, .DONE_O, .WORK_O, .FLAGS_O);

// File: dv/tb_lmr_datapath.sv
// tb_lmr_datapath: command table with preloads and expected results.
// drives the datapath ports directly; no far-side model.
`timescale 1ns/1ps
module tb_lmr_datapath
  import lmr_pkg::*;
  ;
  typedef struct packed {
    logic [3:0] op;
    lmr_flags_type f, ef;
    logic [7:0] m, w, ew, em;
  } lmr_row_type;
  // op, flags in, flags out, memory in, work in, work out, memory out
  logic [39:0] rows [10] = '{40'h1f_a5_3c_a5_a5, 40'h2a_a5_3c_3c_3c,
    40'h38_81_10_91_81, 40'h42_00_00_00_00, 40'h4d_0f_f0_f0_ff,
    40'h5f_81_00_00_03, 40'h6a_81_00_03_81, 40'h74_41_00_00_83,
    40'h85_80_00_01_80, 40'h0f_12_34_34_12};
  lmr_row_type r;
  logic clk = 1'h0, nrst = 1'h0, cv = 1'h0, mv = 1'h0, wv = 1'h0, fv = 1'h0;
  logic rdy, done;
  lmr_cmd_type cmd = 12'h000;
  lmr_flags_type fd = 2'h0, flags;
  logic [7:0] ma = 8'h00, md = 8'h00, wd = 8'h00, pa = 8'h00, pd, work;
  int errors = 0, n_tests = 0;
  lmr_datapath uut (.CLK_I(clk), .NRST_I(nrst), .CMD_VALID_I(cv), .CMD_I(cmd),
    .CMD_READY_O(rdy), .DONE_O(done), .MEM_LOAD_VALID_I(mv),
    .MEM_LOAD_ADDR_I(ma), .MEM_LOAD_DATA_I(md), .WORK_LOAD_VALID_I(wv),
    .WORK_LOAD_DATA_I(wd), .FLAG_LOAD_VALID_I(fv), .FLAG_LOAD_I(fd),
    .MEM_PEEK_ADDR_I(pa), .MEM_PEEK_DATA_O(pd), .WORK_O(work),
    .FLAGS_O(flags));
  initial forever #2 clk = ~clk;
  task step();
    @(posedge clk) #1;
  endtask : step
  task chk(input string n, input logic [15:0] e, s);
    n_tests++;
    errors += int'(e !== s);
    if (e !== s) $display("MISMATCH %s exp %h got %h", n, e, s);
  endtask : chk
  // done is polled under a bound so a dead datapath cannot hang here
  task run(input logic [3:0] op, input logic [7:0] a);
    {cv, cmd} = {1'h1, op, a};
    step();
    cv = 1'h0;
    for (int k = 0; k < 8 && done !== 1'h1; k++) step();
    chk("done", 16'h0001, {15'h0000, done});
  endtask : run
  task complete_run();
    if (errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  initial
  begin
    repeat (2000) @(posedge clk);
    errors++;
    complete_run();
  end
  initial
  begin
    repeat (10) step();
    nrst = 1'h1;
    foreach (rows[i])
    begin
      r = rows[i];
      {ma, md, wd, fd} = {8'(i), r.m, r.w, r.f};
      {mv, wv, fv} = 3'h7;
      step();
      {mv, wv, fv} = 3'h0;
      run(r.op, 8'(i));
      chk("wf", {r.ew, 6'h00, r.ef}, {work, 6'h00, flags});
      pa = 8'(i);
      step();
      chk("mem", {8'h00, r.em}, {8'h00, pd});
    end
    run(4'h8, 8'h01);
    chk("b2b", 16'h7902, {work, 6'h00, flags});
    run(4'h8, 8'h08);
    chk("b2b", 16'h0003, {work, 6'h00, flags});
    nrst = 1'h0;
    #1;
    chk("reset", 16'h0002, {work, 4'h0, flags, rdy, done});
    step();
    nrst = 1'h1;
    // memory keeps its bytes across reset; first command at first edge
    run(4'h1, 8'h08);
    chk("post", 16'h8000, {work, 6'h00, flags});
    complete_run();
  end
endmodule : tb_lmr_datapath
